// [hdl/alu_regs.svh]
`ifndef ALU_REGS_SVH
`define ALU_REGS_SVH

// Positions of the status flags inside the flag vector
`define FLAG_C      0
`define FLAG_Z      1
`define FLAG_N      2
`define FLAG_V      3
`define FLAG_S      4
`define FLAG_H      5
`define FLAG_WIDTH  6

// Reset and constant values
`define FLAGS_RESET 6'h00
`define BYTE_ZERO   8'h00
`define BYTE_ONES   8'hFF
`define BYTE_ONE    8'h01
`define WORD_ZERO   16'h0000

`endif

// [hdl/alu_pkg.sv]
package alu_pkg;

  typedef enum logic [4:0] {
    sum_regs,
    sum_carry_regs,
    word_sum_imm,
    difference_regs,
    difference_imm,
    difference_borrow_regs,
    difference_borrow_imm,
    word_difference_imm,
    conjunction_regs,
    conjunction_imm,
    disjunction_regs,
    disjunction_imm,
    xor_regs,
    bit_invert,
    arith_sign_flip,
    set_bits_imm,
    clear_bits_imm,
    plus_one,
    minus_one,
    test_zero_minus,
    zero_register,
    fill_ones,
    product_unsigned,
    product_signed,
    product_mixed_sign,
    fraction_product_unsigned,
    fraction_product_signed
  } alu_op_t;

  typedef enum logic {
    st_idle,
    st_finish
  } alu_state_t;

endpackage

// [hdl/byte_addsub.sv]
// Eight-bit adder and subtractor with carry, half-carry and overflow
module byte_addsub (
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  input  wire logic       carry_in,
  input  wire logic       subtract,
  output logic      [7:0] sum,
  output logic            carry_out,
  output logic            half_out,
  output logic            ovf_out
);

  logic [8:0] full;
  logic [4:0] nibble;

  // Subtraction reports a borrow, not an inverted carry
  assign full      = subtract ? ({1'b0, op_a} - {1'b0, op_b} - {8'h00, carry_in})
                              : ({1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_in});
  assign nibble    = subtract ? ({1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, carry_in})
                              : ({1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in});
  assign sum       = full[7:0];
  assign carry_out = full[8];
  assign half_out  = nibble[4];
  assign ovf_out   = subtract ? ((op_a[7] & ~op_b[7] & ~sum[7]) | (~op_a[7] & op_b[7] & sum[7]))
                              : ((op_a[7] & op_b[7] & ~sum[7]) | (~op_a[7] & ~op_b[7] & sum[7]));

endmodule // byte_addsub

// [hdl/mult_unit.sv]
`include "alu_regs.svh"
// Registered 8x8 multiplier, signed or unsigned per operand
module mult_unit (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [7:0]  mcand,
  input  wire logic [7:0]  mplier,
  input  wire logic        signed_a,
  input  wire logic        signed_b,
  input  wire logic        fractional,
  output logic      [15:0] product,
  output logic             carry
);

  logic signed [8:0]  a_ext;
  logic signed [8:0]  b_ext;
  logic signed [17:0] raw;
  logic        [14:0] raw_low;
  logic               raw_top;

  // Ninth bit lets one multiplier serve all sign mixes
  assign a_ext   = {signed_a & mcand[7], mcand};
  assign b_ext   = {signed_b & mplier[7], mplier};
  assign raw     = a_ext * b_ext;
  assign raw_low = raw[14:0];
  assign raw_top = raw[15];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      product <= `WORD_ZERO;
      carry   <= 1'b0;
    end else if (load) begin
      product <= fractional ? {raw_low, 1'b0} : raw[15:0];
      carry   <= raw_top;
    end
  end

  AST_FRAC_SHIFT: assert property (@(posedge ref_clk) disable iff (rst)
    load && fractional |=> product == {$past(raw_low), 1'b0} && carry == $past(raw_top))
    else $error("fractional product not shifted");

endmodule // mult_unit

// [hdl/arith_logic_multiply_unit.sv]
// Operation
// - register sums write dst+src(+carry), one cycle
// - word sum adds constant to pair, two cycles
// - register difference writes dst minus src
// - constant difference writes dst minus constant
// - register borrow difference subtracts src and carry
// - constant borrow difference subtracts constant and carry
// - word difference subtracts constant, two cycles
// - register AND, flags Z N V only
// - constant AND, flags Z N V only
// - OR with register or constant, Z N V
// - XOR of registers, flags Z N V
// - invert is FF-dst; sign flip 00-dst
// - set bits ORs a mask, Z N V
// - clear bits ANDs with inverted mask
// - plus/minus one keep carry, Z N V
// - test ANDs dst with itself
// - zero register XORs; fill ones keeps flags
// - products go to R1:R0, Z C, two cycles
// - unsigned fractional product shifted left once
// - signed fractional product shifted left once
`include "alu_regs.svh"
module arith_logic_multiply_unit (
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           start,
  input  alu_pkg::alu_op_t    op,
  input  wire logic [7:0]     dst_val,
  input  wire logic [7:0]     dst_hi_val,
  input  wire logic [7:0]     src_val,
  input  wire logic [7:0]     imm_val,
  output logic      [7:0]     result_lo,
  output logic      [7:0]     result_hi,
  output logic                wr_lo,
  output logic                wr_hi,
  output logic                pair_r1r0,
  output logic                done,
  output logic                busy,
  output logic      [5:0]     flags
);

  alu_pkg::alu_state_t state;
  alu_pkg::alu_op_t    cur_op;

  logic        accept;
  logic        carry_in;
  logic        is_word;
  logic        is_mul;
  logic        is_sign_flip;
  logic        adder_op;
  logic        uses_imm;
  logic        step_op;
  logic        do_sub;
  logic        use_cin;
  logic [7:0]  add_a;
  logic [7:0]  add_b;
  logic        add_cin;
  logic [7:0]  add_r;
  logic        add_c;
  logic        add_h;
  logic        add_v;
  logic [7:0]  single_res;
  logic [5:0]  single_flags;
  logic [15:0] word_in;
  logic        word_sub;
  logic [15:0] word_r;
  logic        word_v;
  logic        word_c;
  logic [5:0]  word_flags;
  logic [15:0] word_hold;
  logic [5:0]  word_flags_hold;
  logic        mul_signed_a;
  logic        mul_signed_b;
  logic        mul_frac;
  logic [15:0] product;
  logic        product_c;
  logic [5:0]  mul_flags;

  function automatic logic is_zero8(input logic [7:0] r);
    return r == `BYTE_ZERO;
  endfunction

  // Z, N set from result; V cleared; others untouched
  function automatic logic [5:0] logic_flags(input logic [5:0] old, input logic [7:0] r);
    logic [5:0] f;
    f          = old;
    f[`FLAG_Z] = is_zero8(r);
    f[`FLAG_N] = r[7];
    f[`FLAG_V] = 1'b0;
    return f;
  endfunction

  function automatic logic [5:0] step_flags(input logic [5:0] old, input logic [7:0] r,
                                            input logic v);
    logic [5:0] f;
    f          = logic_flags(old, r);
    f[`FLAG_V] = v;
    return f;
  endfunction

  function automatic logic [5:0] arith_flags(input logic [5:0] old, input logic [7:0] r,
                                             input logic c, input logic v, input logic h);
    logic [5:0] f;
    f          = step_flags(old, r, v);
    f[`FLAG_C] = c;
    f[`FLAG_H] = h;
    return f;
  endfunction

  assign accept   = start && !busy;
  assign carry_in = flags[`FLAG_C];
  assign is_word  = op inside {alu_pkg::word_sum_imm, alu_pkg::word_difference_imm};
  assign is_mul   = op inside {alu_pkg::product_unsigned, alu_pkg::product_signed,
                               alu_pkg::product_mixed_sign, alu_pkg::fraction_product_unsigned,
                               alu_pkg::fraction_product_signed};

  // Shared byte adder operand selection
  assign is_sign_flip = op == alu_pkg::arith_sign_flip;
  assign uses_imm     = op inside {alu_pkg::difference_imm, alu_pkg::difference_borrow_imm};
  assign step_op      = op inside {alu_pkg::plus_one, alu_pkg::minus_one};
  assign do_sub       = op inside {alu_pkg::difference_regs, alu_pkg::difference_imm,
                                   alu_pkg::difference_borrow_regs, alu_pkg::difference_borrow_imm,
                                   alu_pkg::arith_sign_flip, alu_pkg::minus_one};
  assign use_cin      = op inside {alu_pkg::sum_carry_regs, alu_pkg::difference_borrow_regs,
                                   alu_pkg::difference_borrow_imm};
  assign add_a        = is_sign_flip ? `BYTE_ZERO : dst_val;
  assign add_b        = is_sign_flip ? dst_val : step_op ? `BYTE_ONE : uses_imm ? imm_val : src_val;
  assign add_cin      = use_cin & carry_in;

  byte_addsub u_addsub (
    .op_a      (add_a),
    .op_b      (add_b),
    .carry_in  (add_cin),
    .subtract  (do_sub),
    .sum       (add_r),
    .carry_out (add_c),
    .half_out  (add_h),
    .ovf_out   (add_v)
  );

  always_comb begin
    single_res = dst_val;
    case (op)
      alu_pkg::sum_regs, alu_pkg::sum_carry_regs, alu_pkg::difference_regs,
      alu_pkg::difference_imm, alu_pkg::difference_borrow_regs,
      alu_pkg::difference_borrow_imm, alu_pkg::arith_sign_flip,
      alu_pkg::plus_one, alu_pkg::minus_one: single_res = add_r;
      alu_pkg::conjunction_regs: single_res = dst_val & src_val;
      alu_pkg::conjunction_imm:  single_res = dst_val & imm_val;
      alu_pkg::disjunction_regs:                       single_res = dst_val | src_val;
      alu_pkg::disjunction_imm, alu_pkg::set_bits_imm: single_res = dst_val | imm_val;
      alu_pkg::xor_regs:        single_res = dst_val ^ src_val;
      alu_pkg::bit_invert:      single_res = `BYTE_ONES - dst_val;
      alu_pkg::clear_bits_imm:  single_res = dst_val & (`BYTE_ONES - imm_val);
      alu_pkg::test_zero_minus: single_res = dst_val & dst_val;
      alu_pkg::zero_register:   single_res = dst_val ^ dst_val;
      alu_pkg::fill_ones:       single_res = `BYTE_ONES;
      default:                  single_res = dst_val;
    endcase
  end

  // ops that take all adder flags
  assign adder_op     = op inside {alu_pkg::sum_regs, alu_pkg::sum_carry_regs,
                                   alu_pkg::difference_regs, alu_pkg::difference_imm,
                                   alu_pkg::difference_borrow_regs,
                                   alu_pkg::difference_borrow_imm, alu_pkg::arith_sign_flip};

  assign single_flags = adder_op ? arith_flags(flags, add_r, add_c, add_v, add_h)
                      : step_op ? step_flags(flags, add_r, add_v)
                      : (op == alu_pkg::bit_invert)
                        ? arith_flags(flags, single_res, 1'h1, 1'h0, flags[`FLAG_H])
                      : (op == alu_pkg::fill_ones) ? flags
                      : logic_flags(flags, single_res);

  assign word_in  = {dst_hi_val, dst_val};
  assign word_sub = op == alu_pkg::word_difference_imm;
  assign word_r   = word_sub ? (word_in - {8'h00, imm_val}) : (word_in + {8'h00, imm_val});
  assign word_v   = word_sub ? (dst_hi_val[7] & ~word_r[15]) : (~dst_hi_val[7] & word_r[15]);
  assign word_c   = word_sub ? (word_r[15] & ~dst_hi_val[7]) : (~word_r[15] & dst_hi_val[7]);

  always_comb begin
    word_flags          = flags;
    word_flags[`FLAG_Z] = word_r == `WORD_ZERO;
    word_flags[`FLAG_C] = word_c;
    word_flags[`FLAG_N] = word_r[15];
    word_flags[`FLAG_V] = word_v;
    word_flags[`FLAG_S] = word_r[15] ^ word_v;
  end

  assign mul_signed_a = op inside {alu_pkg::product_signed, alu_pkg::product_mixed_sign,
                                   alu_pkg::fraction_product_signed};
  assign mul_signed_b = op inside {alu_pkg::product_signed, alu_pkg::fraction_product_signed};
  assign mul_frac     = op inside {alu_pkg::fraction_product_unsigned,
                                   alu_pkg::fraction_product_signed};

  mult_unit u_mult (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .load       (accept && is_mul),
    .mcand      (dst_val),
    .mplier     (src_val),
    .signed_a   (mul_signed_a),
    .signed_b   (mul_signed_b),
    .fractional (mul_frac),
    .product    (product),
    .carry      (product_c)
  );

  always_comb begin
    mul_flags          = flags;
    mul_flags[`FLAG_Z] = product == `WORD_ZERO;
    mul_flags[`FLAG_C] = product_c;
  end

  // Requests while busy are dropped, not queued
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state           <= alu_pkg::st_idle;
      cur_op          <= alu_pkg::sum_regs;
      result_lo       <= `BYTE_ZERO;
      result_hi       <= `BYTE_ZERO;
      wr_lo           <= 1'b0;
      wr_hi           <= 1'b0;
      pair_r1r0       <= 1'b0;
      done            <= 1'b0;
      busy            <= 1'b0;
      flags           <= `FLAGS_RESET;
      word_hold       <= `WORD_ZERO;
      word_flags_hold <= `FLAGS_RESET;
    end else begin
      wr_lo <= 1'b0;
      wr_hi <= 1'b0;
      done  <= 1'b0;
      case (state)
        alu_pkg::st_idle: begin
          if (accept) begin
            cur_op <= op;
            if (is_word || is_mul) begin
              state           <= alu_pkg::st_finish;
              busy            <= 1'b1;
              word_hold       <= word_r;
              word_flags_hold <= word_flags;
            end else begin
              result_lo <= single_res;
              flags     <= single_flags;
              pair_r1r0 <= 1'b0;
              wr_lo     <= 1'b1;
              done      <= 1'b1;
            end
          end
        end
        alu_pkg::st_finish: begin
          state     <= alu_pkg::st_idle;
          busy      <= 1'b0;
          wr_lo     <= 1'b1;
          wr_hi     <= 1'b1;
          done      <= 1'b1;
          pair_r1r0 <= cur_op != alu_pkg::word_sum_imm && cur_op != alu_pkg::word_difference_imm;
          if (cur_op == alu_pkg::word_sum_imm || cur_op == alu_pkg::word_difference_imm) begin
            {result_hi, result_lo} <= word_hold;
            flags                  <= word_flags_hold;
          end else begin
            {result_hi, result_lo} <= product;
            flags                  <= mul_flags;
          end
        end
        default: begin
          state <= alu_pkg::st_idle;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_SUM_RESULT: assert property (
    accept && op == alu_pkg::sum_regs |=>
      done && wr_lo && result_lo == 8'($past(dst_val) + $past(src_val)))
    else $error("register sum wrong or late");
  AST_DIFF_RESULT: assert property (
    accept && op == alu_pkg::difference_regs |=>
      done && result_lo == 8'($past(dst_val) - $past(src_val))
      && flags[`FLAG_C] == ($past(src_val) > $past(dst_val)))
    else $error("register difference wrong");
  AST_LOGIC_FLAGS: assert property (
    accept && op inside {alu_pkg::conjunction_regs, alu_pkg::xor_regs} |=>
      !flags[`FLAG_V] && flags[`FLAG_C] == $past(flags[`FLAG_C])
      && flags[`FLAG_H] == $past(flags[`FLAG_H]) && flags[`FLAG_N] == result_lo[7])
    else $error("logic operation flags wrong");
  AST_CLEAR_BITS: assert property (
    accept && op == alu_pkg::clear_bits_imm |=> result_lo == ($past(dst_val) & ~$past(imm_val)))
    else $error("clear bits result wrong");
  AST_STEP_CARRY: assert property (
    accept && step_op |=> done && flags[`FLAG_C] == $past(flags[`FLAG_C]))
    else $error("plus or minus one touched carry");
  AST_FILL_KEEPS: assert property (
    accept && op == alu_pkg::fill_ones |=> result_lo == `BYTE_ONES && flags == $past(flags))
    else $error("fill ones result or flags wrong");
  AST_WORD_TWO: assert property (
    accept && is_word |=> busy && !done ##1 done && wr_hi && !pair_r1r0)
    else $error("word operation not two cycles");
  AST_MUL_PRODUCT: assert property (
    accept && op == alu_pkg::product_unsigned |=> !done ##1
      done && pair_r1r0
      && {result_hi, result_lo} == {8'h00, $past(dst_val, 2)} * {8'h00, $past(src_val, 2)})
    else $error("unsigned product wrong or late");
  AST_WORD_SIGN: assert property (
    done && (cur_op == alu_pkg::word_sum_imm || cur_op == alu_pkg::word_difference_imm) |->
      flags[`FLAG_S] == (flags[`FLAG_N] ^ flags[`FLAG_V]))
    else $error("sign flag not N xor V");
  AST_MUL_KEEPS: assert property (
    accept && is_mul |=> ##1 flags[`FLAG_N] == $past(flags[`FLAG_N], 2)
      && flags[`FLAG_V] == $past(flags[`FLAG_V], 2))
    else $error("product changed unlisted flags");

endmodule // arith_logic_multiply_unit

// [test/reg_file_model.sv]
// Register file side of the unit: takes write-back pulses into its registers
module reg_file_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       wr_lo,
  input  wire logic       wr_hi,
  input  wire logic       pair_r1r0,
  input  wire logic [7:0] result_lo,
  input  wire logic [7:0] result_hi,
  output logic      [7:0] r0,
  output logic      [7:0] r1,
  output logic      [7:0] dst_reg,
  output logic      [7:0] dst_hi_reg
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {r1, r0, dst_hi_reg, dst_reg} <= 32'h0000_0000;
    end else begin
      if (wr_lo && pair_r1r0) r0 <= result_lo;
      if (wr_hi && pair_r1r0) r1 <= result_hi;
      if (wr_lo && !pair_r1r0) dst_reg <= result_lo;
      if (wr_hi && !pair_r1r0) dst_hi_reg <= result_hi;
    end
  end
endmodule // reg_file_model

// [test/arith_logic_multiply_unit_tb.sv]
module arith_logic_multiply_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic             ref_clk = 1'h0;
  logic             rst = 1'h1;
  logic             start = 1'h0;
  alu_pkg::alu_op_t op = alu_pkg::sum_regs;
  logic [7:0]       dst_val = 8'h00;
  logic [7:0]       dst_hi_val = 8'h00;
  logic [7:0]       src_val = 8'h00;
  logic [7:0]       imm_val = 8'h00;
  logic [7:0]       result_lo, result_hi, r0, r1, dst_reg, dst_hi_reg;
  logic             wr_lo, wr_hi, pair_r1r0, done, busy;
  logic [5:0]       flags;
  logic [5:0]       exp_flags = 6'h00;
  logic [7:0]       exp_hi = 8'h00;
  int               err_total = 0;
  int               samples_checked = 0;

  always #4 ref_clk = ~ref_clk;

  arith_logic_multiply_unit dut (.ref_clk(ref_clk), .rst(rst), .start(start), .op(op),
    .dst_val(dst_val), .dst_hi_val(dst_hi_val), .src_val(src_val), .imm_val(imm_val),
    .result_lo(result_lo), .result_hi(result_hi), .wr_lo(wr_lo), .wr_hi(wr_hi),
    .pair_r1r0(pair_r1r0), .done(done), .busy(busy), .flags(flags));

  reg_file_model rf (.ref_clk(ref_clk), .rst(rst), .wr_lo(wr_lo), .wr_hi(wr_hi),
    .pair_r1r0(pair_r1r0), .result_lo(result_lo), .result_hi(result_hi), .r0(r0),
    .r1(r1), .dst_reg(dst_reg), .dst_hi_reg(dst_hi_reg));

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_data(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic check_flags(input logic [5:0] g, input logic [5:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic check_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Returns {H,S,V,N,Z,C, hi byte, lo byte}
  function automatic logic [21:0] ref_op(input alu_pkg::alu_op_t o, input logic [7:0] d,
      input logic [7:0] h, input logic [7:0] s, input logic [7:0] k, input logic [5:0] f);
    logic [8:0]  a;
    logic [4:0]  hn;
    logic [7:0]  aa, b, r, hi;
    logic [15:0] w, p;
    logic        c, z, n, v, sg, hh, cin, ad, sb, sa, sm, wd;
    {hh, sg, v, n, z, c} = f;
    hi = 8'h00;
    r = d;
    a = 9'h000;
    hn = 5'h00;
    ad = o inside {alu_pkg::sum_regs, alu_pkg::sum_carry_regs};
    sb = o inside {alu_pkg::difference_regs, alu_pkg::difference_imm, alu_pkg::arith_sign_flip,
                   alu_pkg::difference_borrow_regs, alu_pkg::difference_borrow_imm};
    wd = o inside {alu_pkg::word_sum_imm, alu_pkg::word_difference_imm};
    aa = (o == alu_pkg::arith_sign_flip) ? 8'h00 : d;
    b = (o == alu_pkg::arith_sign_flip) ? d :
        (o inside {alu_pkg::difference_imm, alu_pkg::difference_borrow_imm}) ? k : s;
    cin = f[0] & (o inside {alu_pkg::sum_carry_regs, alu_pkg::difference_borrow_regs,
                            alu_pkg::difference_borrow_imm});
    if (ad) begin
      a = aa + b + cin;
      hn = aa[3:0] + b[3:0] + cin;
      v = (aa[7] & b[7] & ~a[7]) | (~aa[7] & ~b[7] & a[7]);
    end
    if (sb) begin
      a = aa - b - cin;
      hn = aa[3:0] - b[3:0] - cin;
      v = (aa[7] & ~b[7] & ~a[7]) | (~aa[7] & b[7] & a[7]);
    end
    if (ad | sb) begin
      r = a[7:0];
      c = a[8];
      hh = hn[4];
    end
    case (o)
      alu_pkg::conjunction_regs: r = d & s;
      alu_pkg::conjunction_imm: r = d & k;
      alu_pkg::disjunction_regs: r = d | s;
      alu_pkg::disjunction_imm, alu_pkg::set_bits_imm: r = d | k;
      alu_pkg::xor_regs: r = d ^ s;
      alu_pkg::clear_bits_imm: r = d & ~k;
      alu_pkg::zero_register: r = 8'h00;
      alu_pkg::bit_invert: {c, r} = {1'h1, ~d};
      alu_pkg::plus_one: r = d + 8'h01;
      alu_pkg::minus_one: r = d - 8'h01;
      alu_pkg::fill_ones: r = 8'hFF;
      default: ;
    endcase
    if (!wd && o < alu_pkg::product_unsigned && o != alu_pkg::fill_ones) begin
      z = (r == 8'h00);
      n = r[7];
      if (!ad && !sb) v = (o == alu_pkg::plus_one && d == 8'h7F) ||
                          (o == alu_pkg::minus_one && d == 8'h80);
    end
    if (wd) begin
      w = (o == alu_pkg::word_sum_imm) ? {h, d} + {8'h00, k} : {h, d} - {8'h00, k};
      {hi, r} = w;
      n = w[15];
      z = (w == 16'h0000);
      v = (o == alu_pkg::word_sum_imm) ? ~h[7] & w[15] : h[7] & ~w[15];
      c = (o == alu_pkg::word_sum_imm) ? ~w[15] & h[7] : w[15] & ~h[7];
      sg = n ^ v;
    end
    if (o >= alu_pkg::product_unsigned) begin
      sa = o inside {alu_pkg::product_signed, alu_pkg::product_mixed_sign,
                     alu_pkg::fraction_product_signed};
      sm = o inside {alu_pkg::product_signed, alu_pkg::fraction_product_signed};
      p = {{8{sa & d[7]}}, d} * {{8{sm & s[7]}}, s};
      c = p[15];
      if (o >= alu_pkg::fraction_product_unsigned) p = p << 1;
      {hi, r} = p;
      z = (p == 16'h0000);
    end
    return {hh, sg, v, n, z, c, hi, r};
  endfunction

  task automatic run_op(input alu_pkg::alu_op_t o, input logic [7:0] d, input logic [7:0] h,
      input logic [7:0] s, input logic [7:0] k);
    logic [21:0] e;
    logic        prd, two;
    int          n;
    e = ref_op(o, d, h, s, k, exp_flags);
    prd = (o >= alu_pkg::product_unsigned);
    two = prd || o inside {alu_pkg::word_sum_imm, alu_pkg::word_difference_imm};
    @(posedge ref_clk);
    start <= 1'h1;
    op <= o;
    {dst_val, dst_hi_val, src_val, imm_val} <= {d, h, s, k};
    @(posedge ref_clk);
    start <= 1'h0;
    n = 1;
    #1;
    if (two) check_bit(busy, 1'h1);
    while (done !== 1'h1 && n < 6) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (done !== 1'h1) begin
      check_bit(done, 1'h1);
      test_done;
    end
    check_data(16'(n), two ? 16'h0002 : 16'h0001);
    check_bit(wr_lo, 1'h1);
    check_bit(wr_hi, two);
    check_bit(pair_r1r0, prd);
    if (two) exp_hi = e[15:8];
    check_data({result_hi, result_lo}, {exp_hi, e[7:0]});
    check_flags(flags, e[21:16]);
    exp_flags = e[21:16];
  endtask

  task automatic t_reset;
    #1;
    check_flags(flags, 6'h00);
    check_data({result_hi, result_lo}, 16'h0000);
    check_bit(done | busy | wr_lo | wr_hi | pair_r1r0, 1'h0);
    $display("reset test finished");
  endtask

  task automatic t_add;
    run_op(alu_pkg::sum_regs, 8'h03, 8'h00, 8'h04, 8'h00);
    run_op(alu_pkg::sum_regs, 8'h80, 8'h00, 8'h80, 8'h00);
    run_op(alu_pkg::sum_carry_regs, 8'h0F, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::sum_carry_regs, 8'h7F, 8'h00, 8'h00, 8'h00);
    $display("add test finished");
  endtask

  task automatic t_sub;
    run_op(alu_pkg::difference_regs, 8'h00, 8'h00, 8'h01, 8'h00);
    run_op(alu_pkg::difference_borrow_regs, 8'h10, 8'h00, 8'h0F, 8'h00);
    run_op(alu_pkg::difference_imm, 8'h80, 8'h00, 8'h00, 8'h01);
    run_op(alu_pkg::difference_imm, 8'h05, 8'h00, 8'h00, 8'h07);
    run_op(alu_pkg::difference_borrow_imm, 8'h05, 8'h00, 8'h33, 8'h00);
    $display("sub test finished");
  endtask

  task automatic t_word;
    run_op(alu_pkg::word_sum_imm, 8'hFF, 8'hFF, 8'h00, 8'h01);
    run_op(alu_pkg::word_sum_imm, 8'hC1, 8'h7F, 8'h00, 8'h3F);
    run_op(alu_pkg::word_difference_imm, 8'h00, 8'h00, 8'h00, 8'h01);
    run_op(alu_pkg::word_difference_imm, 8'h00, 8'h80, 8'h00, 8'h3F);
    @(posedge ref_clk);
    #1;
    check_data({dst_hi_reg, dst_reg}, 16'h7FC1);
    $display("word test finished");
  endtask

  task automatic t_logic;
    run_op(alu_pkg::sum_regs, 8'h80, 8'h00, 8'h80, 8'h00);
    run_op(alu_pkg::conjunction_regs, 8'hA5, 8'h00, 8'h0F, 8'h00);
    run_op(alu_pkg::conjunction_imm, 8'h80, 8'h00, 8'h00, 8'hF0);
    run_op(alu_pkg::disjunction_regs, 8'h00, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::disjunction_imm, 8'h12, 8'h00, 8'h00, 8'h81);
    run_op(alu_pkg::xor_regs, 8'hAA, 8'h00, 8'hAA, 8'h00);
    run_op(alu_pkg::set_bits_imm, 8'h01, 8'h00, 8'h00, 8'h80);
    run_op(alu_pkg::clear_bits_imm, 8'hFF, 8'h00, 8'h00, 8'h0F);
    run_op(alu_pkg::test_zero_minus, 8'h80, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::zero_register, 8'h5A, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::fill_ones, 8'h00, 8'h00, 8'h00, 8'h00);
    $display("logic test finished");
  endtask

  task automatic t_unary;
    run_op(alu_pkg::bit_invert, 8'h00, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::arith_sign_flip, 8'h00, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::arith_sign_flip, 8'h80, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::arith_sign_flip, 8'h01, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::plus_one, 8'h7F, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::plus_one, 8'hFF, 8'h00, 8'h00, 8'h00);
    run_op(alu_pkg::minus_one, 8'h80, 8'h00, 8'h00, 8'h00);
    $display("unary test finished");
  endtask

  task automatic t_product;
    run_op(alu_pkg::product_unsigned, 8'hFF, 8'h00, 8'hFF, 8'h00);
    run_op(alu_pkg::product_unsigned, 8'h00, 8'h00, 8'h37, 8'h00);
    run_op(alu_pkg::product_signed, 8'h80, 8'h00, 8'h80, 8'h00);
    run_op(alu_pkg::product_mixed_sign, 8'hFF, 8'h00, 8'hFF, 8'h00);
    run_op(alu_pkg::fraction_product_unsigned, 8'hC0, 8'h00, 8'hC0, 8'h00);
    run_op(alu_pkg::fraction_product_signed, 8'h80, 8'h00, 8'h40, 8'h00);
    @(posedge ref_clk);
    #1;
    check_data({r1, r0}, 16'hC000);
    $display("product test finished");
  endtask

  task automatic t_b2b;
    logic [21:0] e;
    e = ref_op(alu_pkg::plus_one, 8'h7F, 8'h00, 8'h00, 8'h00, exp_flags);
    @(posedge ref_clk);
    start <= 1'h1;
    op <= alu_pkg::plus_one;
    dst_val <= 8'h7F;
    @(posedge ref_clk);
    op <= alu_pkg::minus_one;
    dst_val <= 8'h00;
    #1;
    check_bit(done, 1'h1);
    check_data({8'h00, result_lo}, {8'h00, e[7:0]});
    check_flags(flags, e[21:16]);
    e = ref_op(alu_pkg::minus_one, 8'h00, 8'h00, 8'h00, 8'h00, e[21:16]);
    @(posedge ref_clk);
    start <= 1'h0;
    #1;
    check_bit(done, 1'h1);
    check_data({8'h00, result_lo}, {8'h00, e[7:0]});
    check_flags(flags, e[21:16]);
    exp_flags = e[21:16];
    $display("back to back test finished");
  endtask

  // A start while busy is dropped, not queued
  task automatic t_refuse;
    @(posedge ref_clk);
    start <= 1'h1;
    op <= alu_pkg::product_unsigned;
    {dst_val, src_val} <= 16'h1010;
    @(posedge ref_clk);
    op <= alu_pkg::plus_one;
    dst_val <= 8'h05;
    @(posedge ref_clk);
    start <= 1'h0;
    #1;
    check_bit(done, 1'h1);
    check_data({result_hi, result_lo}, 16'h0100);
    @(posedge ref_clk);
    #1;
    check_bit(done | wr_lo, 1'h0);
    exp_hi = 8'h01;
    exp_flags[1:0] = 2'h0;
    $display("refuse test finished");
  endtask

  task automatic t_rerun;
    @(posedge ref_clk);
    start <= 1'h1;
    op <= alu_pkg::product_unsigned;
    @(posedge ref_clk);
    start <= 1'h0;
    rst <= 1'h1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    rst <= 1'h0;
    #1;
    check_bit(done | busy | wr_lo | wr_hi, 1'h0);
    check_flags(flags, 6'h00);
    exp_flags = 6'h00;
    exp_hi = 8'h00;
    run_op(alu_pkg::plus_one, 8'h00, 8'h00, 8'h00, 8'h00);
    $display("mid-run reset test finished");
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset;
    t_add;
    t_sub;
    t_word;
    t_logic;
    t_unary;
    t_product;
    t_b2b;
    t_refuse;
    t_rerun;
    test_done;
  end
endmodule // arith_logic_multiply_unit_tb
